// *** hw/hprs_home_seq.sv ***
`timescale 1ns/1ps
module hprs_home_seq
  import hprs_pkg::*;
#(
  parameter int          PROG_DEPTH  = 16,
  parameter int          PROG_AW     = 4,
  parameter logic [15:0] CNT_PER_REV = 16'h1000
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 home_return_command,
  input  wire logic [PROG_AW-1:0]   prog_select,
  input  wire logic                 servo_on,
  input  wire logic                 marker_in,
  input  wire logic                 index_in,
  input  wire logic                 enc_step,
  input  wire logic                 enc_dir_neg,
  input  wire logic                 motion_stalled,
  output logic                      motion_run,
  output logic                      motion_fast,
  output logic                      motion_dir_neg,
  output logic                      homing_busy,
  output logic                      homed,
  output logic [31:0]               current_position
);

  hprs_state_t      state_ff;
  logic [4:0]       homing_type_setting_ff;
  logic             function_select_t3_ff;
  logic [31:0]      home_shift_ff;
  logic [31:0]      travel_after_ff;
  logic [31:0]      home_position_data_ff;
  logic [31:0]      cur_pos_ff;
  logic [31:0]      rem_ff;
  logic             dir_neg_ff;
  logic             homed_ff;
  logic             bad_cmd_ff;
  logic             marker_prev_ff;
  logic             index_prev_ff;
  logic             servo_prev_ff;
  logic             idx_block_ff;
  logic [15:0]      idx_cnt_ff;
  logic             aw_held_ff;
  logic             w_held_ff;
  logic [7:0]       aw_addr_ff;
  logic [31:0]      w_data_ff;
  logic [3:0]       w_strb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [31:0]      rdata_ff;
  logic [1:0]       rresp_ff;
  logic             motion_run_ff;
  logic             motion_fast_ff;
  logic             motion_dir_neg_ff;
  logic [7:0]       prog_op;
  logic [3:0]       method;
  logic             marker_det;
  logic             marker_lead;
  logic             marker_trail;
  logic             index_hit;
  logic             wr_fire;
  logic             prog_wr;
  logic             load_home;

  // Decodes whether an address names a mapped register.
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a <= ADDR_PROG_WRITE);
  endfunction : addr_mapped

  // Applies the byte strobes of a write to a stored word.
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    strobe_merge = r;
  endfunction : strobe_merge

  // Marker detection follows the selected input polarity.
  assign marker_det   = function_select_t3_ff ? marker_in : ~marker_in;
  assign marker_lead  = marker_det & ~marker_prev_ff;
  assign marker_trail = ~marker_det & marker_prev_ff;
  // An index edge counts only if none was accepted in the last half revolution.
  assign index_hit    = index_in & ~index_prev_ff & ~idx_block_ff;
  assign method       = homing_type_setting_ff[HT_METHOD_LSB +: 4];
  assign wr_fire      = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign prog_wr      = wr_fire && (aw_addr_ff == ADDR_PROG_WRITE);
  // Home is loaded at completion, or at servo-on under the ignore method.
  assign load_home    = (state_ff == ST_DONE)
                      | (servo_on & ~servo_prev_ff & (method == METH_IGNORE));

  hprs_prog_mem #(
    .WIDTH (8),
    .DEPTH (PROG_DEPTH),
    .AW    (PROG_AW)
  ) u_prog_mem (
    .aclk       (aclk),
    .wr_en      (prog_wr),
    .wr_addr    (w_data_ff[PW_SLOT_LSB +: PROG_AW]),
    .wr_data    (w_data_ff[7:0]),
    .rd_addr    (prog_select),
    .rd_data_ff (prog_op)
  );

  // Write address and data are held separately, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // Write response follows both halves; unmapped or read-only gives SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (addr_mapped(aw_addr_ff) && aw_addr_ff != ADDR_STATUS
                    && aw_addr_ff != ADDR_CUR_POS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      homing_type_setting_ff <= HOMING_TYPE_RST;
      function_select_t3_ff  <= POLARITY_RST;
      home_shift_ff          <= DIST_RST;
      travel_after_ff        <= DIST_RST;
      home_position_data_ff  <= DIST_RST;
    end else if (wr_fire) begin
      unique case (aw_addr_ff)
        ADDR_HOMING_TYPE: begin
          if (w_strb_ff[0]) begin
            homing_type_setting_ff <= w_data_ff[4:0];
          end
        end
        ADDR_FUNC_SEL_T3: begin
          if (w_strb_ff[0]) begin
            function_select_t3_ff <= w_data_ff[POL_BIT];
          end
        end
        ADDR_HOME_SHIFT:    home_shift_ff <= strobe_merge(home_shift_ff, w_data_ff, w_strb_ff);
        ADDR_TRAVEL_AFTER:  travel_after_ff <= strobe_merge(travel_after_ff, w_data_ff,
                                                            w_strb_ff);
        ADDR_HOME_POS_DATA: home_position_data_ff <= strobe_merge(home_position_data_ff,
                                                                  w_data_ff, w_strb_ff);
        default: ;
      endcase
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_HOMING_TYPE:   rdata_ff <= {27'h0, homing_type_setting_ff};
        ADDR_FUNC_SEL_T3:   rdata_ff <= {31'h0, function_select_t3_ff};
        ADDR_HOME_SHIFT:    rdata_ff <= home_shift_ff;
        ADDR_TRAVEL_AFTER:  rdata_ff <= travel_after_ff;
        ADDR_HOME_POS_DATA: rdata_ff <= home_position_data_ff;
        ADDR_STATUS:        rdata_ff <= {29'h0, bad_cmd_ff, homed_ff,
                                         (state_ff != ST_IDLE)};
        ADDR_CUR_POS:       rdata_ff <= cur_pos_ff;
        default:            rdata_ff <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Input history for edge detection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      marker_prev_ff <= 1'b0;
      index_prev_ff  <= 1'b0;
      servo_prev_ff  <= 1'b0;
    end else begin
      marker_prev_ff <= marker_det;
      index_prev_ff  <= index_in;
      servo_prev_ff  <= servo_on;
    end
  end

  // After an accepted index, further edges are ignored for half a revolution.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_block_ff <= 1'b0;
      idx_cnt_ff   <= 16'h0000;
    end else if (index_hit) begin
      idx_block_ff <= 1'b1;
      idx_cnt_ff   <= 16'h0000;
    end else if (idx_block_ff && enc_step) begin
      idx_cnt_ff <= idx_cnt_ff + 16'h0001;
      if (idx_cnt_ff + 16'h0001 >= (CNT_PER_REV >> 1)) begin
        idx_block_ff <= 1'b0;
      end
    end
  end

  // Current position follows the encoder and is overwritten at home.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_pos_ff <= 32'h0000_0000;
    end else if (load_home) begin
      cur_pos_ff <= home_position_data_ff;
    end else if (enc_step) begin
      cur_pos_ff <= enc_dir_neg ? cur_pos_ff - 32'h1 : cur_pos_ff + 32'h1;
    end
  end

  // Homed flag is clear from power-up until home is loaded, at completion or at servo-on under the ignore method.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      homed_ff <= 1'b0;
    end else if (load_home) begin
      homed_ff <= 1'b1;
    end else if (state_ff == ST_FETCH) begin
      homed_ff <= 1'b0;
    end
  end

  // Homing sequencer: program fetch, method decode and motion phases.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_IDLE;
      rem_ff     <= 32'h0000_0000;
      dir_neg_ff <= 1'b0;
      bad_cmd_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (home_return_command) begin
            state_ff <= ST_FETCH;
          end
        end
        ST_FETCH: state_ff <= ST_DECODE;
        ST_DECODE: begin
          dir_neg_ff <= homing_type_setting_ff[HT_DIR_BIT];
          bad_cmd_ff <= (prog_op != OP_HOME_RETURN);
          if (prog_op != OP_HOME_RETURN) begin
            state_ff <= ST_IDLE;
          end else begin
            unique case (method)
              METH_DATA_SET, METH_IGNORE: state_ff <= ST_DONE;
              METH_STOPPER:               state_ff <= ST_STOPPER;
              METH_DOGLESS:               state_ff <= ST_INDEX;
              METH_DOG, METH_COUNT, METH_DOG_REAR, METH_COUNT_FRONT, METH_CRADLE,
              METH_LAST_INDEX, METH_DOG_FRONT: begin
                state_ff <= marker_det ? ST_RETRACT : ST_SEEK;
              end
              default: begin
                bad_cmd_ff <= 1'b1;
                state_ff   <= ST_IDLE;
              end
            endcase
          end
        end
        ST_RETRACT: begin
          if (!marker_det) begin
            state_ff <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          if (marker_lead) begin
            unique case (method)
              METH_DOG, METH_DOG_REAR: state_ff <= ST_CREEP;
              METH_COUNT: begin
                rem_ff   <= travel_after_ff;
                state_ff <= ST_TRAVEL;
              end
              METH_COUNT_FRONT, METH_DOG_FRONT: begin
                rem_ff   <= travel_after_ff + home_shift_ff;
                state_ff <= ST_TRAVEL;
              end
              METH_CRADLE: state_ff <= ST_INDEX;
              default: begin
                dir_neg_ff <= ~dir_neg_ff;
                state_ff   <= ST_REVERSE;
              end
            endcase
          end
        end
        ST_CREEP: begin
          if (marker_trail) begin
            if (method == METH_DOG_REAR) begin
              rem_ff   <= travel_after_ff + home_shift_ff;
              state_ff <= ST_TRAVEL;
            end else begin
              state_ff <= ST_INDEX;
            end
          end
        end
        ST_REVERSE: begin
          if (!marker_det) begin
            state_ff <= ST_INDEX;
          end
        end
        ST_TRAVEL: begin
          if (rem_ff == 32'h0) begin
            state_ff <= (method == METH_COUNT) ? ST_INDEX : ST_DONE;
          end else if (enc_step) begin
            rem_ff <= rem_ff - 32'h1;
          end
        end
        ST_INDEX: begin
          if (index_hit) begin
            rem_ff   <= home_shift_ff;
            state_ff <= (method == METH_CRADLE) ? ST_DONE : ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (rem_ff == 32'h0) begin
            state_ff <= ST_DONE;
          end else if (enc_step) begin
            rem_ff <= rem_ff - 32'h1;
          end
        end
        ST_STOPPER: begin
          if (motion_stalled) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Motion command outputs: fast until the marker is met, or the index under the dogless method; creep afterwards and throughout the stopper method.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_run_ff     <= 1'b0;
      motion_fast_ff    <= 1'b0;
      motion_dir_neg_ff <= 1'b0;
    end else begin
      motion_run_ff     <= !(state_ff inside {ST_IDLE, ST_FETCH, ST_DECODE, ST_DONE})
                           && !(state_ff == ST_TRAVEL && rem_ff == 32'h0)
                           && !(state_ff == ST_SHIFT && rem_ff == 32'h0)
                           && !(state_ff == ST_INDEX && index_hit && method == METH_CRADLE);
      motion_fast_ff    <= (state_ff == ST_SEEK) || (state_ff == ST_RETRACT)
                           || (state_ff == ST_INDEX && method == METH_DOGLESS);
      motion_dir_neg_ff <= dir_neg_ff ^ (state_ff == ST_RETRACT);
    end
  end

  // Outputs; the accepted index pulse stays internal.
  assign s_axi_awready    = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready     = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid     = bvalid_ff;
  assign s_axi_bresp      = bresp_ff;
  assign s_axi_arready    = ~rvalid_ff;
  assign s_axi_rvalid     = rvalid_ff;
  assign s_axi_rdata      = rdata_ff;
  assign s_axi_rresp      = rresp_ff;
  assign motion_run       = motion_run_ff;
  assign motion_fast      = motion_fast_ff;
  assign motion_dir_neg   = motion_dir_neg_ff;
  assign homing_busy      = (state_ff != ST_IDLE);
  assign homed            = homed_ff;
  assign current_position = cur_pos_ff;

endmodule : hprs_home_seq

// *** hw/hprs_pkg.sv ***
package hprs_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_HOMING_TYPE   = 8'h00;
  localparam logic [7:0] ADDR_FUNC_SEL_T3   = 8'h04;
  localparam logic [7:0] ADDR_HOME_SHIFT    = 8'h08;
  localparam logic [7:0] ADDR_TRAVEL_AFTER  = 8'h0c;
  localparam logic [7:0] ADDR_HOME_POS_DATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS        = 8'h14;
  localparam logic [7:0] ADDR_CUR_POS       = 8'h18;
  localparam logic [7:0] ADDR_PROG_WRITE    = 8'h1c;

  // Field positions.
  localparam int HT_METHOD_LSB   = 0;
  localparam int HT_DIR_BIT      = 4;
  localparam int POL_BIT         = 0;
  localparam int PW_SLOT_LSB     = 16;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_HOMED_BIT    = 1;
  localparam int ST_BADCMD_BIT   = 2;

  // Values after reset.
  localparam logic [4:0]  HOMING_TYPE_RST = 5'h00;
  localparam logic        POLARITY_RST    = 1'h0;
  localparam logic [31:0] DIST_RST        = 32'h0000_0000;

  // Homing method codes held in the method field.
  localparam logic [3:0] METH_DOG         = 4'h0;
  localparam logic [3:0] METH_COUNT       = 4'h1;
  localparam logic [3:0] METH_DATA_SET    = 4'h2;
  localparam logic [3:0] METH_STOPPER     = 4'h3;
  localparam logic [3:0] METH_IGNORE      = 4'h4;
  localparam logic [3:0] METH_DOG_REAR    = 4'h5;
  localparam logic [3:0] METH_COUNT_FRONT = 4'h6;
  localparam logic [3:0] METH_CRADLE      = 4'h7;
  localparam logic [3:0] METH_LAST_INDEX  = 4'h8;
  localparam logic [3:0] METH_DOG_FRONT   = 4'h9;
  localparam logic [3:0] METH_DOGLESS     = 4'ha;

  // Program command code that starts homing.
  localparam logic [7:0] OP_HOME_RETURN = 8'h01;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    ST_IDLE, ST_FETCH, ST_DECODE, ST_RETRACT, ST_SEEK, ST_CREEP, ST_TRAVEL,
    ST_REVERSE, ST_INDEX, ST_SHIFT, ST_STOPPER, ST_DONE
  } hprs_state_t;

endpackage : hprs_pkg

// *** hw/hprs_prog_mem.sv ***
`timescale 1ns/1ps
module hprs_prog_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             aclk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_ff
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // Stored program commands, written from the register bus.
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  // Read data leave through a register, one cycle after the address.
  always_ff @(posedge aclk) begin
    rd_data_ff <= mem_ff[rd_addr];
  end

endmodule : hprs_prog_mem

// *** tb/hprs_axis_model.sv ***
`timescale 1ns/1ps
module hprs_axis_model #(
  parameter int MK_LO = 40,
  parameter int MK_HI = 80,
  parameter int REV   = 16,
  parameter int STOP  = -30
) (
  input  wire logic aclk,
  input  wire logic motion_run,
  input  wire logic motion_fast,
  input  wire logic motion_dir_neg,
  input  wire logic pol,
  output logic      marker_in,
  output logic      index_in,
  output logic      enc_step,
  output logic      enc_dir_neg,
  output logic      motion_stalled
);
  int   pos = 0;
  int   nxt;
  logic ph  = 1'h0;
  // Raw switch level; on the marker it shows the selected detect level.
  assign marker_in      = (pos >= MK_LO && pos <= MK_HI) ~^ pol;
  assign enc_dir_neg    = motion_dir_neg;
  assign motion_stalled = motion_run && motion_dir_neg && pos <= STOP;
  // One count per cycle fast, every other cycle at creep; index once a turn.
  always @(posedge aclk) begin
    nxt = pos + (motion_dir_neg ? -1 : 1);
    ph <= ~ph;
    enc_step <= 1'h0;
    index_in <= 1'h0;
    if (motion_run && !motion_stalled && (motion_fast || ph)) begin
      pos <= nxt;
      enc_step <= 1'h1;
      index_in <= (nxt % REV) == 0;
    end
  end
endmodule : hprs_axis_model

// *** tb/hprs_home_seq_asserts.sv ***
`timescale 1ns/1ps
module hprs_home_seq_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        home_return_command,
  input wire logic        homing_busy,
  input wire logic        motion_run,
  input wire logic        homed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers stand until taken and come within the hand-over latency.
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // Homing control outputs.
  a_start_busy: assert property (!homing_busy && home_return_command |=> homing_busy)
    else $error("command not taken in idle");
  a_homed_reset: assert property (!$past(aresetn) |-> !homed)
    else $error("homed set after reset");
  a_homed_hold: assert property (homed && !homing_busy && !home_return_command |=> homed)
    else $error("homed lost without start");
  a_idle_still: assert property (!homing_busy ##1 !homing_busy |-> !motion_run)
    else $error("axis runs while idle");
endmodule : hprs_home_seq_chk
bind hprs_home_seq hprs_home_seq_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .home_return_command, .homing_busy, .motion_run,
  .homed);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import hprs_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, pol = 1'h0, servo_on = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, current_position;
  logic [3:0]  s_axi_wstrb = 4'hf, prog_select = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, home_return_command = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        marker_in, index_in, enc_step, enc_dir_neg, motion_stalled;
  logic        motion_run, motion_fast, motion_dir_neg, homing_busy, homed;
  int          n_fail = 0, n_compared = 0;
  localparam logic [31:0] HPD = 32'h0000_0abc;
  // Rows: method, start direction, polarity, homed expected.
  logic [6:0]  rows [12] = '{7'h01, 7'h0b, 7'h11, 7'h1d, 7'h21, 7'h29, 7'h33, 7'h39,
                             7'h41, 7'h49, 7'h55, 7'h58};

  hprs_home_seq #(.CNT_PER_REV(16'h0010)) u_hprs_home_seq (.*);
  hprs_axis_model u_axis (.*);

  // Free-running bus clock.
  initial forever #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!b);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, v;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      t = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (t) s_axi_arvalid <= 1'h0;
    end while (!v);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  // Starts a program and waits for the sequencer; notes the first move's direction.
  task automatic run(input logic [3:0] s, output logic sn, output logic dn);
    logic b;
    int   i;
    sn = 1'h0;
    dn = 1'h0;
    i = 0;
    prog_select <= s;
    home_return_command <= 1'h1;
    @(posedge aclk);
    home_return_command <= 1'h0;
    do begin
      @(negedge aclk);
      b = homing_busy;
      if (motion_run && !sn) begin
        sn = 1'h1;
        dn = motion_dir_neg;
      end
      @(posedge aclk);
      i++;
    end while ((b || i < 3) && i < 3000);
    if (i >= 3000) begin
      n_fail++;
      $display("[FAIL] %0t homing did not finish", $time);
    end
  endtask : run

  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Watchdog against a hung handshake or sequence.
  initial begin
    #(100 * 60000);
    n_fail++;
    complete_run;
  end

  // Main sequence: reset, table of methods, then the awkward cases.
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        sn, dn;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(ADDR_HOMING_TYPE, d, r);
    chk(d, {27'h0, HOMING_TYPE_RST});
    rd(ADDR_STATUS, d, r);
    chk(d, 32'h0);
    rd(8'h20, d, r);
    chk(r, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h7, r);
    chk(r, RESP_SLVERR);
    wr(ADDR_HOME_SHIFT, 32'h3, r);
    wr(ADDR_TRAVEL_AFTER, 32'h5, r);
    wr(ADDR_HOME_POS_DATA, HPD, r);
    wr(ADDR_PROG_WRITE, 32'h0000_0001, r);
    wr(ADDR_PROG_WRITE, 32'h0001_007e, r);
    foreach (rows[i]) begin
      wr(ADDR_HOMING_TYPE, {27'h0, rows[i][2], rows[i][6:3]}, r);
      wr(ADDR_FUNC_SEL_T3, {31'h0, rows[i][1]}, r);
      pol <= rows[i][1];
      u_axis.pos = 0;
      run(4'h0, sn, dn);
      rd(ADDR_STATUS, d, r);
      chk(d[ST_HOMED_BIT], rows[i][0]);
      if (sn) chk(dn, rows[i][2]);
      if (rows[i][0]) chk(current_position, HPD);
      else chk(d[ST_BADCMD_BIT], 1'h1);
    end
    // Start while sitting on the marker: the axis must back out first.
    wr(ADDR_HOMING_TYPE, 32'h0, r);
    u_axis.pos = 60;
    run(4'h0, sn, dn);
    chk(dn, 1'h1);
    chk(homed, 1'h1);
    // A program without the home-return command must not home.
    run(4'h1, sn, dn);
    chk(homed, 1'h0);
    // Servo-on edge loads home under the ignore method.
    wr(ADDR_HOMING_TYPE, {28'h0, METH_IGNORE}, r);
    wr(ADDR_HOME_POS_DATA, 32'h0000_0555, r);
    servo_on <= 1'h1;
    repeat (4) @(posedge aclk);
    chk(current_position, 32'h0000_0555);
    rd(ADDR_CUR_POS, d, r);
    chk(d, 32'h0000_0555);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    chk(homed, 1'h0);
    complete_run;
  end
endmodule : tb_top
